// ### common/gpms_params.svh
`ifndef GPMS_PARAMS_SVH
`define GPMS_PARAMS_SVH

// ==========================================================================
// Register offsets on the management port.
`define GPMS_OFF_LP_NP 5'h08
`define GPMS_OFF_GCTL 5'h09
`define GPMS_OFF_GSTAT 5'h0a

// ==========================================================================
// Control register fields and reset value.
`define GPMS_CTL_TM_HI 15
`define GPMS_CTL_TM_LO 13
`define GPMS_CTL_MAN_EN 12
`define GPMS_CTL_MAN_VAL 11
`define GPMS_CTL_PORT 10
`define GPMS_CTL_FDX 9
`define GPMS_CTL_HDX 8
`define GPMS_CTL_RESET 16'h0300

// ==========================================================================
// Partner next-page fields.
`define GPMS_NP_MORE 15
`define GPMS_NP_ACK 14
`define GPMS_NP_MSG 13
`define GPMS_NP_ACK2 12
`define GPMS_NP_TGL 11

// ==========================================================================
// Status register fields and reset values.
`define GPMS_ST_FAULT 15
`define GPMS_ST_RES 14
`define GPMS_ST_LOC 13
`define GPMS_ST_REM 12
`define GPMS_ST_LPF 11
`define GPMS_ST_LPH 10
`define GPMS_RES_RESET 1'b1
`define GPMS_IDLE_MAX 8'hff

// ==========================================================================
// Role arbitration and test pattern constants.
`define GPMS_MAX_RETRY 3'h7
`define GPMS_SCR_SEED 11'h001
`define GPMS_SYM_PERIOD_NS 4'h8
`define GPMS_CLK_PERIOD_NS 4'h5
`define GPMS_RUN_LEN_LOG2 7

`endif

// ### common/gpms_pkg.sv
`include "gpms_params.svh"

package gpms_pkg;

  // ========================================================================
  // Test mode codes, in the order of their field encoding.
  typedef enum logic [2:0] {
    TM_NORMAL, TM_WAVE, TM_JIT_M, TM_JIT_S, TM_DIST, TM_RSV5, TM_RSV6, TM_RSV7
  } gpms_tmode_e;

  typedef logic signed [2:0] gpms_sym_t;

  localparam gpms_sym_t SYM_ZERO = 3'h0;
  localparam gpms_sym_t SYM_P1 = 3'h1;
  localparam gpms_sym_t SYM_P2 = 3'h2;
  localparam gpms_sym_t SYM_M1 = 3'h7;
  localparam gpms_sym_t SYM_M2 = 3'h6;

  // ========================================================================
  // Module state records.
  typedef struct packed {
    logic [15:0] ctl;
    logic [15:0] ctl_lat;
    logic [15:0] np;
    logic np_seen;
    logic tgl_err;
    logic fault;
    logic [7:0] idle;
    logic [15:0] rdata;
  } gpms_top_s;

  typedef struct packed {
    logic [3:0] acc;
    logic [9:0] cnt;
    logic [10:0] scr;
    gpms_sym_t sym;
    logic vld;
    logic active;
    logic master_tm;
  } gpms_pat_s;

  typedef struct packed {
    logic [10:0] seed;
    logic [2:0] retry;
    logic master;
    logic fault;
    logic done;
  } gpms_role_s;

endpackage

// ### common/gpms_core_if.sv
`timescale 1ns/1ps

interface gpms_core_if;
  gpms_pkg::gpms_tmode_e test_mode;
  logic test_en;
  gpms_pkg::gpms_sym_t sym;
  logic sym_vld;
  logic active;
  logic master_tm;
  logic resolve_req;
  logic loc_man_en;
  logic loc_man_val;
  logic loc_port;
  logic lp_man_en;
  logic lp_man_val;
  logic lp_port;
  logic [10:0] lp_seed;
  logic master;
  logic fault_evt;
  logic done;

  modport top (
    output test_mode, test_en, resolve_req, loc_man_en, loc_man_val, loc_port,
    output lp_man_en, lp_man_val, lp_port, lp_seed,
    input sym, sym_vld, active, master_tm, master, fault_evt, done
  );
  modport pat (
    input test_mode, test_en,
    output sym, sym_vld, active, master_tm
  );
  modport role (
    input resolve_req, loc_man_en, loc_man_val, loc_port,
    input lp_man_en, lp_man_val, lp_port, lp_seed,
    output master, fault_evt, done
  );
endinterface

// ### src/gpms_pattern_gen.sv
`timescale 1ns/1ps
`include "gpms_params.svh"

module gpms_pattern_gen (
  input wire logic clk_sys,
  input wire logic arst_n,
  gpms_core_if.pat bus
);
  gpms_pkg::gpms_pat_s s_r;
  gpms_pkg::gpms_pat_s s_nxt;
  logic [3:0] acc_sum;
  logic step;
  logic [2:0] seg;
  logic [2:0] xbits;

  // ========================================================================
  // Symbol pacing: average one symbol per symbol period on the faster clock.
  assign acc_sum = s_r.acc + `GPMS_CLK_PERIOD_NS;
  assign step = (acc_sum >= `GPMS_SYM_PERIOD_NS);
  assign seg = s_r.cnt[9:`GPMS_RUN_LEN_LOG2];
  assign xbits = {s_r.scr[2] ^ s_r.scr[6], s_r.scr[1] ^ s_r.scr[4], s_r.scr[0]}; // RULE_14

  always_comb begin
    s_nxt = s_r;
    s_nxt.vld = 1'b0;
    s_nxt.active = bus.test_en;
    s_nxt.master_tm = bus.test_en && (bus.test_mode != gpms_pkg::TM_JIT_S); // RULE_11
    s_nxt.acc = step ? acc_sum - `GPMS_SYM_PERIOD_NS : acc_sum;
    if (!bus.test_en) begin
      s_nxt.cnt = 10'h000;
      s_nxt.scr = `GPMS_SCR_SEED;
      s_nxt.sym = gpms_pkg::SYM_ZERO;
    end else if (step) begin
      s_nxt.vld = 1'b1;
      s_nxt.cnt = s_r.cnt + 10'h001;
      case (bus.test_mode)
        gpms_pkg::TM_WAVE: begin
          if (!seg[2]) begin // RULE_10
            if (s_r.cnt[6:0] != 7'h00) begin
              s_nxt.sym = gpms_pkg::SYM_ZERO;
            end else begin
              case (seg[1:0])
                2'h0: s_nxt.sym = gpms_pkg::SYM_P2;
                2'h1: s_nxt.sym = gpms_pkg::SYM_M2;
                2'h2: s_nxt.sym = gpms_pkg::SYM_P1;
                default: s_nxt.sym = gpms_pkg::SYM_M1;
              endcase
            end
          end else begin
            s_nxt.sym = seg[0] ? gpms_pkg::SYM_M2 : gpms_pkg::SYM_P2; // RULE_10
          end
        end
        gpms_pkg::TM_JIT_M, gpms_pkg::TM_JIT_S: begin
          s_nxt.sym = s_r.cnt[0] ? gpms_pkg::SYM_M2 : gpms_pkg::SYM_P2; // RULE_11
        end
        gpms_pkg::TM_DIST: begin
          s_nxt.scr = {s_r.scr[9:0], s_r.scr[8] ^ s_r.scr[10]}; // RULE_12
          case (xbits) // RULE_13
            3'h0, 3'h4: s_nxt.sym = gpms_pkg::SYM_ZERO;
            3'h1, 3'h5: s_nxt.sym = gpms_pkg::SYM_P1;
            3'h2: s_nxt.sym = gpms_pkg::SYM_P2;
            3'h6: s_nxt.sym = gpms_pkg::SYM_M2;
            default: s_nxt.sym = gpms_pkg::SYM_M1;
          endcase
        end
        default: s_nxt.sym = gpms_pkg::SYM_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
      s_r.scr <= `GPMS_SCR_SEED;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.sym = s_r.sym;
  assign bus.sym_vld = s_r.vld;
  assign bus.active = s_r.active;
  assign bus.master_tm = s_r.master_tm;

  // ========================================================================
  // Checks.
  scr_step_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_12
    (bus.test_en && bus.test_mode == gpms_pkg::TM_DIST && step) |=>
      s_r.scr == {$past(s_r.scr[9:0]), $past(s_r.scr[8]) ^ $past(s_r.scr[10])})
    else $error("test scrambler did not advance correctly");
  jitter_pair_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_11
    (s_r.vld && s_r.sym == gpms_pkg::SYM_P2 && bus.test_en &&
     bus.test_mode == gpms_pkg::TM_JIT_M && $stable(bus.test_mode)) ##1
      (bus.test_en && bus.test_mode == gpms_pkg::TM_JIT_M) |->
      ##[0:1] (s_r.vld && s_r.sym == gpms_pkg::SYM_M2))
    else $error("jitter pattern did not alternate");
endmodule

// ### src/gpms_role_resolve.sv
`timescale 1ns/1ps
`include "gpms_params.svh"

module gpms_role_resolve (
  input wire logic clk_sys,
  input wire logic arst_n,
  gpms_core_if.role bus
);
  gpms_pkg::gpms_role_s s_r;
  gpms_pkg::gpms_role_s s_nxt;

  // ========================================================================
  // Role decision, taken each time a resolution attempt is requested.
  always_comb begin
    s_nxt = s_r;
    s_nxt.seed = s_r.seed + 11'h001;
    s_nxt.fault = 1'b0;
    s_nxt.done = 1'b0;
    if (bus.resolve_req) begin
      if (bus.loc_man_en && bus.lp_man_en && bus.loc_man_val == bus.lp_man_val) begin
        s_nxt.fault = 1'b1; // RULE_15
        s_nxt.retry = 3'h0;
      end else if (bus.loc_man_en) begin
        s_nxt.master = bus.loc_man_val; // RULE_06
        s_nxt.done = 1'b1;
      end else if (bus.lp_man_en) begin
        s_nxt.master = !bus.lp_man_val; // RULE_05
        s_nxt.done = 1'b1;
      end else if (bus.loc_port != bus.lp_port) begin
        s_nxt.master = bus.loc_port; // RULE_07
        s_nxt.done = 1'b1;
      end else if (s_r.seed != bus.lp_seed) begin
        s_nxt.master = (s_r.seed > bus.lp_seed); // RULE_05
        s_nxt.done = 1'b1;
      end else if (s_r.retry == `GPMS_MAX_RETRY - 3'h1) begin
        s_nxt.fault = 1'b1; // RULE_15
        s_nxt.retry = 3'h0;
      end else begin
        s_nxt.retry = s_r.retry + 3'h1;
      end
      if (s_nxt.done) begin
        s_nxt.retry = 3'h0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
      s_r.master <= `GPMS_RES_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.master = s_r.master;
  assign bus.fault_evt = s_r.fault;
  assign bus.done = s_r.done;

  // ========================================================================
  // Checks.
  manual_force_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_06
    (bus.resolve_req && bus.loc_man_en && !bus.lp_man_en) |=>
      (s_r.done && s_r.master == $past(bus.loc_man_val)))
    else $error("manual role value not applied");
  same_force_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_15
    (bus.resolve_req && bus.loc_man_en && bus.lp_man_en &&
     bus.loc_man_val == bus.lp_man_val) |=> (s_r.fault && !s_r.done))
    else $error("equal forced roles did not raise a fault");
  port_pref_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_07
    (bus.resolve_req && !bus.loc_man_en && !bus.lp_man_en && bus.loc_port &&
     !bus.lp_port) |=> (s_r.done && s_r.master))
    else $error("port preference did not give master");
endmodule

// ### src/gpms_top.sv
`timescale 1ns/1ps
`include "gpms_params.svh"

// What this block does
// [RULE_01] Partner next-page fields are reported read-only at their bit positions.
// [RULE_02] Partner toggle must invert each page; a repeat is flagged.
// [RULE_03] Test mode field acts only at gigabit speed.
// [RULE_04] Codes 0 to 4 are normal and test modes; 5 to 7 reserved.
// [RULE_05] Manual enable clear uses arbitration; set fixes role from the value bit.
// [RULE_06] Value bit ignored unless enabled; 1 forces master, 0 slave.
// [RULE_07] Port type set prefers master; unequal preference makes the side with port type set master.
// [RULE_08] Gigabit ability bits reset to 1; changes act only after renegotiation.
// [RULE_09] Control register is sampled only on entry to ability detect.
// [RULE_10] Test mode one: four pulses with zeros, then four 128-symbol runs.
// [RULE_11] Test modes two and three send +2,-2; master and slave timing.
// [RULE_12] Test mode four: 11-bit scrambler, new bit is bit 8 xor 10.
// [RULE_13] Test mode four maps derived bits to quinary symbols by table.
// [RULE_14] Derived bits are x0=s0, x1=s1^s4, x2=s2^s6.
// [RULE_15] Fault sets on equal forced roles or seven unresolved retries.
// [RULE_16] Fault flag stays latched until the status register is read.
// [RULE_17] Resolution bit resets to 1, 1 means master, changes on resolution.
// [RULE_18] Status bits 13 and 12 mirror local and remote receiver state.
// [RULE_19] Status bits 11 and 10 show partner gigabit full and half duplex.
// [RULE_20] Idle error count clears on read, saturates, counts only at gigabit.
// [RULE_21] Software trusts the next-page register only while page received is set.

module gpms_top (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic speed_gig,
  input wire logic an_ability_detect_enter,
  input wire logic ms_resolve_req,
  input wire logic lp_ms_manual_en,
  input wire logic lp_ms_manual_val,
  input wire logic lp_port_type,
  input wire logic [10:0] lp_seed,
  input wire logic lp_np_strobe,
  input wire logic [15:0] lp_np_word,
  input wire logic lp_gig_fdx,
  input wire logic lp_gig_hdx,
  input wire logic loc_rcvr_ok,
  input wire logic rem_rcvr_ok,
  input wire logic idle_err,
  output logic adv_gig_fdx,
  output logic adv_gig_hdx,
  output logic role_master,
  output logic role_done,
  output logic lp_toggle_err,
  output logic [2:0] tx_sym,
  output logic tx_sym_vld,
  output logic tx_test_active,
  output logic tx_master_timing
);
  gpms_pkg::gpms_top_s s_r;
  gpms_pkg::gpms_top_s s_nxt;
  gpms_core_if core ();
  logic rd_stat;
  logic idle_evt;
  logic [15:0] stat_word;

  gpms_pattern_gen u_pat (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .bus(core.pat)
  );

  gpms_role_resolve u_role (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .bus(core.role)
  );

  // ========================================================================
  // Configuration: local settings from the latched control copy, partner settings and resolve request from the inputs.
  assign core.test_mode = gpms_pkg::gpms_tmode_e'(s_r.ctl_lat[`GPMS_CTL_TM_HI:`GPMS_CTL_TM_LO]);
  assign core.test_en = speed_gig && (core.test_mode != gpms_pkg::TM_NORMAL) && // RULE_03
    (core.test_mode <= gpms_pkg::TM_DIST); // RULE_04
  assign core.resolve_req = ms_resolve_req;
  assign core.loc_man_en = s_r.ctl_lat[`GPMS_CTL_MAN_EN]; // RULE_09
  assign core.loc_man_val = s_r.ctl_lat[`GPMS_CTL_MAN_VAL];
  assign core.loc_port = s_r.ctl_lat[`GPMS_CTL_PORT];
  assign core.lp_man_en = lp_ms_manual_en;
  assign core.lp_man_val = lp_ms_manual_val;
  assign core.lp_port = lp_port_type;
  assign core.lp_seed = lp_seed;

  // ========================================================================
  // Register access and status tracking.
  assign rd_stat = reg_rd && (reg_addr == `GPMS_OFF_GSTAT);
  assign idle_evt = idle_err && speed_gig; // RULE_20

  always_comb begin
    stat_word = 16'h0000;
    stat_word[`GPMS_ST_FAULT] = s_r.fault;
    stat_word[`GPMS_ST_RES] = core.master; // RULE_17
    stat_word[`GPMS_ST_LOC] = loc_rcvr_ok; // RULE_18
    stat_word[`GPMS_ST_REM] = rem_rcvr_ok; // RULE_18
    stat_word[`GPMS_ST_LPF] = lp_gig_fdx; // RULE_19
    stat_word[`GPMS_ST_LPH] = lp_gig_hdx; // RULE_19
    stat_word[7:0] = s_r.idle;
  end

  always_comb begin
    s_nxt = s_r;
    if (reg_wr && reg_addr == `GPMS_OFF_GCTL) begin
      s_nxt.ctl = reg_wdata;
    end
    if (an_ability_detect_enter) begin
      s_nxt.ctl_lat = s_r.ctl; // RULE_09
      s_nxt.np_seen = 1'b0;
    end
    if (lp_np_strobe) begin
      s_nxt.np = lp_np_word; // RULE_01
      s_nxt.np_seen = 1'b1;
      s_nxt.tgl_err = s_r.np_seen && (lp_np_word[`GPMS_NP_TGL] == s_r.np[`GPMS_NP_TGL]); // RULE_02
    end
    if (core.fault_evt) begin
      s_nxt.fault = 1'b1; // RULE_15
    end else if (rd_stat) begin
      s_nxt.fault = 1'b0; // RULE_16
    end
    if (rd_stat) begin
      s_nxt.idle = idle_evt ? 8'h01 : 8'h00; // RULE_20
    end else if (idle_evt && s_r.idle != `GPMS_IDLE_MAX) begin
      s_nxt.idle = s_r.idle + 8'h01; // RULE_20
    end
    if (reg_rd) begin
      if (reg_addr == `GPMS_OFF_LP_NP) begin
        s_nxt.rdata = s_r.np; // RULE_01
      end else if (reg_addr == `GPMS_OFF_GCTL) begin
        s_nxt.rdata = s_r.ctl;
      end else if (reg_addr == `GPMS_OFF_GSTAT) begin
        s_nxt.rdata = stat_word;
      end else begin
        s_nxt.rdata = 16'h0000;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
      s_r.ctl <= `GPMS_CTL_RESET; // RULE_08
      s_r.ctl_lat <= `GPMS_CTL_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign adv_gig_fdx = s_r.ctl_lat[`GPMS_CTL_FDX]; // RULE_08
  assign adv_gig_hdx = s_r.ctl_lat[`GPMS_CTL_HDX]; // RULE_08
  assign role_master = core.master;
  assign role_done = core.done;
  assign lp_toggle_err = s_r.tgl_err;
  assign tx_sym = core.sym;
  assign tx_sym_vld = core.sym_vld;
  assign tx_test_active = core.active;
  assign tx_master_timing = core.master_tm;

  // ========================================================================
  // Checks.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  np_capture_a: assert property (lp_np_strobe |=> s_r.np == $past(lp_np_word)) // RULE_01
    else $error("partner page not captured");
  toggle_check_a: assert property ((lp_np_strobe && s_r.np_seen && // RULE_02
    lp_np_word[`GPMS_NP_TGL] != s_r.np[`GPMS_NP_TGL]) |=> !lp_toggle_err)
    else $error("good toggle flagged as error");
  speed_gate_a: assert property (!speed_gig |=> !tx_test_active) // RULE_03
    else $error("test mode active below gigabit");
  reserved_mode_a: assert property ((core.test_mode > gpms_pkg::TM_DIST) |=> // RULE_04
    !tx_test_active)
    else $error("reserved test code started a pattern");
  ctl_latch_a: assert property (an_ability_detect_enter |=> // RULE_09
    s_r.ctl_lat == $past(s_r.ctl))
    else $error("control not latched on ability detect");
  adv_hold_a: assert property (!an_ability_detect_enter |=> // RULE_08
    ($stable(adv_gig_fdx) && $stable(adv_gig_hdx)))
    else $error("advertisement changed outside ability detect");
  fault_hold_a: assert property ((s_r.fault && !rd_stat) |=> s_r.fault) // RULE_16
    else $error("fault flag dropped without a read");
  fault_clear_a: assert property ((rd_stat && !core.fault_evt) |=> !s_r.fault) // RULE_16
    else $error("fault flag not cleared by status read");
  idle_sat_a: assert property ((s_r.idle == `GPMS_IDLE_MAX && !rd_stat) |=> // RULE_20
    s_r.idle == `GPMS_IDLE_MAX)
    else $error("idle count wrapped");
  idle_gate_a: assert property ((!speed_gig && !rd_stat) |=> $stable(s_r.idle)) // RULE_20
    else $error("idle count moved below gigabit");
  role_stable_a: assert property (!core.done |-> $stable(role_master)) // RULE_17
    else $error("resolution changed without a resolution");
endmodule

// ### bench/gpms_partner.sv
`timescale 1ns/1ps

// ==========================================================================
// Remote link partner: role settings, abilities and received next pages.
module gpms_partner (
  input wire logic clk_sys,
  output logic lp_ms_manual_en,
  output logic lp_ms_manual_val,
  output logic lp_port_type,
  output logic [10:0] lp_seed,
  output logic lp_np_strobe,
  output logic [15:0] lp_np_word,
  output logic lp_gig_fdx,
  output logic lp_gig_hdx
);
  logic tgl_r;

  initial begin
    lp_ms_manual_en = 1'b0;
    lp_ms_manual_val = 1'b0;
    lp_port_type = 1'b0;
    lp_seed = 11'h000;
    lp_np_strobe = 1'b0;
    lp_np_word = 16'h0000;
    lp_gig_fdx = 1'b1;
    lp_gig_hdx = 1'b1;
    tgl_r = 1'b0;
  end

  // Sends one page after a delay; a repeated toggle is a deliberate fault.
  task automatic send_page(input logic [15:0] f, input int gap, input logic rep,
                           output logic [15:0] w);
    repeat (gap + 1) @(negedge clk_sys);
    if (!rep) begin
      tgl_r = ~tgl_r;
    end
    w = {f[15:12], tgl_r, f[10:0]};
    lp_np_word = w;
    lp_np_strobe = 1'b1;
    @(negedge clk_sys);
    lp_np_strobe = 1'b0;
    lp_np_word = ~w;
  endtask

  task automatic set_role(input logic en, input logic val, input logic port);
    @(negedge clk_sys);
    lp_ms_manual_en = en;
    lp_ms_manual_val = val;
    lp_port_type = port;
  endtask

  task automatic set_abil(input logic fdx, input logic hdx);
    lp_gig_fdx = fdx;
    lp_gig_hdx = hdx;
  endtask
endmodule

// ### bench/tb_top.sv
`timescale 1ns/1ps
`include "gpms_params.svh"

module tb_top;
  logic clk_sys;
  logic arst_n;
  logic [4:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic speed_gig;
  logic an_ability_detect_enter;
  logic ms_resolve_req;
  logic lp_ms_manual_en;
  logic lp_ms_manual_val;
  logic lp_port_type;
  logic [10:0] lp_seed;
  logic lp_np_strobe;
  logic [15:0] lp_np_word;
  logic lp_gig_fdx;
  logic lp_gig_hdx;
  logic loc_rcvr_ok;
  logic rem_rcvr_ok;
  logic idle_err;
  logic adv_gig_fdx;
  logic adv_gig_hdx;
  logic role_master;
  logic role_done;
  logic lp_toggle_err;
  logic [2:0] tx_sym;
  logic tx_sym_vld;
  logic tx_test_active;
  logic tx_master_timing;
  int fail_count;
  int num_checks;
  int cycles;

  gpms_top i_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .speed_gig(speed_gig),
    .an_ability_detect_enter(an_ability_detect_enter), .ms_resolve_req(ms_resolve_req),
    .lp_ms_manual_en(lp_ms_manual_en), .lp_ms_manual_val(lp_ms_manual_val),
    .lp_port_type(lp_port_type), .lp_seed(lp_seed), .lp_np_strobe(lp_np_strobe),
    .lp_np_word(lp_np_word), .lp_gig_fdx(lp_gig_fdx), .lp_gig_hdx(lp_gig_hdx),
    .loc_rcvr_ok(loc_rcvr_ok), .rem_rcvr_ok(rem_rcvr_ok), .idle_err(idle_err),
    .adv_gig_fdx(adv_gig_fdx), .adv_gig_hdx(adv_gig_hdx), .role_master(role_master),
    .role_done(role_done), .lp_toggle_err(lp_toggle_err), .tx_sym(tx_sym),
    .tx_sym_vld(tx_sym_vld), .tx_test_active(tx_test_active),
    .tx_master_timing(tx_master_timing)
  );

  gpms_partner i_partner (
    .clk_sys(clk_sys), .lp_ms_manual_en(lp_ms_manual_en),
    .lp_ms_manual_val(lp_ms_manual_val), .lp_port_type(lp_port_type), .lp_seed(lp_seed),
    .lp_np_strobe(lp_np_strobe), .lp_np_word(lp_np_word), .lp_gig_fdx(lp_gig_fdx),
    .lp_gig_hdx(lp_gig_hdx)
  );

  always #2.5 clk_sys = ~clk_sys;

  // ========================================================================
  // Common tasks.
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      summarize();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic reg_write(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask

  task automatic reg_read(input logic [4:0] a, output logic [15:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    reg_read(a, d);
    check(d, exp);
  endtask

  task automatic set_mode(input logic [2:0] m);
    reg_write(`GPMS_OFF_GCTL, {m, 13'h0300});
    @(negedge clk_sys);
    an_ability_detect_enter = 1'b1;
    @(negedge clk_sys);
    an_ability_detect_enter = 1'b0;
  endtask

  task automatic next_sym(output logic [2:0] s);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (!(tx_sym_vld === 1'b1 && tx_test_active === 1'b1) && n < 24) begin
      @(negedge clk_sys);
      n++;
    end
    s = tx_sym;
  endtask

  // ========================================================================
  // Scenarios.
  task automatic t_reset();
    logic [15:0] d;
    check({adv_gig_fdx, adv_gig_hdx, role_master}, 3'h7);
    rd_chk(`GPMS_OFF_GCTL, 16'h0300);
    reg_read(`GPMS_OFF_GSTAT, d);
    check(d[15:14], 2'h1);
    rd_chk(5'h1f, 16'h0000);
  endtask

  task automatic t_page();
    logic [15:0] w;
    i_partner.send_page(16'ha5a5, 0, 1'b0, w);
    i_partner.send_page(16'h5123, 3, 1'b0, w);
    repeat (2) @(negedge clk_sys);
    check(lp_toggle_err, 1'b0);
    reg_write(`GPMS_OFF_LP_NP, 16'hffff);
    rd_chk(`GPMS_OFF_LP_NP, w);
    i_partner.send_page(16'hd7fe, 0, 1'b1, w);
    repeat (2) @(negedge clk_sys);
    check(lp_toggle_err, 1'b1);
    rd_chk(`GPMS_OFF_LP_NP, w);
  endtask

  task automatic t_latch();
    speed_gig = 1'b1;
    reg_write(`GPMS_OFF_GCTL, 16'h20a5);
    repeat (3) @(negedge clk_sys);
    check({adv_gig_fdx, adv_gig_hdx, tx_test_active}, 3'h6);
    rd_chk(`GPMS_OFF_GCTL, 16'h20a5);
    @(negedge clk_sys);
    an_ability_detect_enter = 1'b1;
    @(negedge clk_sys);
    an_ability_detect_enter = 1'b0;
    repeat (2) @(negedge clk_sys);
    check({adv_gig_fdx, adv_gig_hdx, tx_test_active}, 3'h1);
  endtask

  task automatic t_status();
    logic [15:0] d;
    for (int i = 0; i < 16; i++) begin
      loc_rcvr_ok = i[3];
      rem_rcvr_ok = i[2];
      i_partner.set_abil(i[1], i[0]);
      reg_read(`GPMS_OFF_GSTAT, d);
      check(d[13:12], i[3:2]);
      check(d[11:10], i[1:0]);
    end
  endtask

  task automatic t_idle();
    logic [15:0] d;
    reg_read(`GPMS_OFF_GSTAT, d);
    repeat (3) begin
      @(negedge clk_sys);
      idle_err = 1'b1;
      @(negedge clk_sys);
      idle_err = 1'b0;
    end
    reg_read(`GPMS_OFF_GSTAT, d);
    check(d[7:0], 8'h03);
    reg_read(`GPMS_OFF_GSTAT, d);
    check(d[7:0], 8'h00);
    speed_gig = 1'b0;
    repeat (2) begin
      @(negedge clk_sys);
      idle_err = 1'b1;
      @(negedge clk_sys);
      idle_err = 1'b0;
    end
    reg_read(`GPMS_OFF_GSTAT, d);
    check(d[7:0], 8'h00);
    speed_gig = 1'b1;
    repeat (300) begin
      @(negedge clk_sys);
      idle_err = 1'b1;
      @(negedge clk_sys);
      idle_err = 1'b0;
    end
    reg_read(`GPMS_OFF_GSTAT, d);
    check(d[7:0], `GPMS_IDLE_MAX);
  endtask

  task automatic t_role();
    logic [15:0] d;
    logic got;
    logic [6:0] cs [5] = '{7'h40, 7'h61, 7'h26, 7'h11, 7'h02};
    for (int i = 0; i < 5; i++) begin
      set_mode(3'h0);
      reg_write(`GPMS_OFF_GCTL, {3'h0, cs[i][6:4], 10'h300});
      an_ability_detect_enter = 1'b1;
      @(negedge clk_sys);
      an_ability_detect_enter = 1'b0;
      i_partner.set_role(cs[i][3], cs[i][2], cs[i][1]);
      ms_resolve_req = 1'b1;
      @(negedge clk_sys);
      ms_resolve_req = 1'b0;
      got = (role_done === 1'b1);
      repeat (4) begin
        @(negedge clk_sys);
        got = got | (role_done === 1'b1);
      end
      check({got, role_master}, {1'b1, cs[i][0]});
      reg_read(`GPMS_OFF_GSTAT, d);
      check(d[14], cs[i][0]);
    end
  endtask

  task automatic t_fault();
    logic [15:0] d;
    reg_write(`GPMS_OFF_GCTL, 16'h1b00);
    an_ability_detect_enter = 1'b1;
    @(negedge clk_sys);
    an_ability_detect_enter = 1'b0;
    i_partner.set_role(1'b1, 1'b1, 1'b0);
    ms_resolve_req = 1'b1;
    @(negedge clk_sys);
    ms_resolve_req = 1'b0;
    repeat (6) @(negedge clk_sys);
    reg_read(`GPMS_OFF_GSTAT, d);
    check(d[15], 1'b1);
    reg_read(`GPMS_OFF_GSTAT, d);
    check(d[15], 1'b0);
    i_partner.set_role(1'b0, 1'b0, 1'b0);
  endtask

  task automatic t_modes();
    logic act;
    for (int m = 0; m < 8; m++) begin
      set_mode(3'(m));
      repeat (2) @(negedge clk_sys);
      act = (m >= 1 && m <= 4);
      check({tx_test_active, tx_master_timing}, {act, act && m != 3});
    end
    speed_gig = 1'b0;
    set_mode(3'h1);
    repeat (2) @(negedge clk_sys);
    check(tx_test_active, 1'b0);
    speed_gig = 1'b1;
    set_mode(3'h0);
  endtask

  task automatic t_wave();
    logic [2:0] s;
    int z;
    z = 0;
    set_mode(3'h1);
    next_sym(s);
    check(s, 3'h2);
    repeat (127) begin
      next_sym(s);
      z = z + int'(s !== 3'h0);
    end
    check(16'(z), 16'h0000);
    next_sym(s);
    check(s, 3'h6);
    set_mode(3'h0);
  endtask

  task automatic t_jitter();
    logic [2:0] s;
    set_mode(3'h2);
    for (int i = 0; i < 8; i++) begin
      next_sym(s);
      check(s, (i % 2) ? 3'h6 : 3'h2);
    end
    set_mode(3'h0);
  endtask

  task automatic t_dist();
    logic [2:0] s;
    logic [10:0] scr;
    logic [2:0] lut [8] = '{3'h0, 3'h1, 3'h2, 3'h7, 3'h0, 3'h1, 3'h6, 3'h7};
    scr = `GPMS_SCR_SEED;
    set_mode(3'h4);
    repeat (24) begin
      next_sym(s);
      check(s, lut[{scr[2] ^ scr[6], scr[1] ^ scr[4], scr[0]}]);
      scr = {scr[9:0], scr[8] ^ scr[10]};
    end
    check(tx_master_timing, 1'b1);
  endtask

  // ========================================================================
  // Main sequence.
  initial begin
    clk_sys = 1'b0;
    arst_n = 1'b0;
    reg_addr = 5'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
    speed_gig = 1'b0;
    an_ability_detect_enter = 1'b0;
    ms_resolve_req = 1'b0;
    loc_rcvr_ok = 1'b0;
    rem_rcvr_ok = 1'b0;
    idle_err = 1'b0;
    fail_count = 0;
    num_checks = 0;
    repeat (10) @(negedge clk_sys);
    arst_n = 1'b1;
    t_reset();
    t_page();
    t_latch();
    t_status();
    t_idle();
    t_role();
    t_fault();
    t_modes();
    t_wave();
    t_jitter();
    t_dist();
    summarize();
  end
endmodule
